/* verilog/lodhp_pkg.sv */
package lodhp_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 2;
  localparam int SRC_W = 6;
  localparam int NUM_SRC = 64;
  localparam int DLY_W = 16;
  localparam int HOLD_W = 14;

  // ----------------------------------------------------------------
  // Source selection codes
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_NONE = 6'h00;
  localparam logic [SRC_W-1:0] SRC_NO_FAULT = 6'h01;
  localparam logic [SRC_W-1:0] SRC_OUTPUT_CONTACTOR_CTRL = 6'h02;
  localparam logic [SRC_W-1:0] SRC_DC_PRECHARGE_CTRL = 6'h03;
  localparam logic [SRC_W-1:0] SRC_LINE_CONTACTOR_CTRL = 6'h04;

  // ----------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [DLY_W-1:0] DLY_MAX_MS = 16'hea60;
  localparam logic [HOLD_W-1:0] HOLD_MAX_MS = 14'h270f;
  localparam logic [DLY_W-1:0] DLY_RST = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_RST = 14'h0000;
  localparam logic POL_RST = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MS_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_CYCLES_DEF = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [3:0] CH_PAGE_FIRST = 4'h1;
  localparam logic [3:0] CH_PAGE_LAST = 4'h2;
  localparam logic [3:0] OFF_SRC = 4'h0;
  localparam logic [3:0] OFF_DLY = 4'h4;
  localparam logic [3:0] OFF_POL = 4'h8;
  localparam logic [3:0] OFF_HOLD = 4'hc;
  localparam int ST_CARD_BIT = 0;
  localparam int ST_LEVEL_BIT = 1;
  localparam int ST_TIMED_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Locked assignments
  // ----------------------------------------------------------------
  function automatic logic dly_fixed(input logic [SRC_W-1:0] s);
    return (s == SRC_NO_FAULT) || (s == SRC_OUTPUT_CONTACTOR_CTRL) ||
           (s == SRC_DC_PRECHARGE_CTRL) || (s == SRC_LINE_CONTACTOR_CTRL);
  endfunction : dly_fixed

  function automatic logic pol_locked(input logic [SRC_W-1:0] s);
    return (s == SRC_NO_FAULT) || (s == SRC_DC_PRECHARGE_CTRL) ||
           (s == SRC_LINE_CONTACTOR_CTRL);
  endfunction : pol_locked

  function automatic logic hold_fixed(input logic [SRC_W-1:0] s);
    return (s == SRC_NO_FAULT) || (s == SRC_DC_PRECHARGE_CTRL) ||
           (s == SRC_LINE_CONTACTOR_CTRL);
  endfunction : hold_fixed

endpackage : lodhp_pkg

/* verilog/lodhp_tick.sv */
`timescale 1ns/10ps
module lodhp_tick
  import lodhp_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Millisecond enable
  output logic tick
);

  localparam int CW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } lodhp_tick_state_type;

  lodhp_tick_state_type q;
  lodhp_tick_state_type d;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("Tick period must be at least two cycles.");
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == CW'(TICK_CYCLES - 1)) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  tick_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.tick |=> !q.tick)
    else $error("Millisecond enable lasted more than one cycle.");

endmodule : lodhp_tick

/* verilog/lodhp_chan.sv */
`timescale 1ns/10ps
module lodhp_chan
  import lodhp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Time base and card
  input wire logic ms_tick,
  input wire logic enable,
  // Condition and settings
  input wire logic cond,
  input wire logic [DLY_W-1:0] on_delay,
  input wire logic [HOLD_W-1:0] hold_time,
  input wire logic active_low,
  // Result
  output logic level,
  output logic timed_state
);

  typedef struct packed {
    logic st;
    logic [DLY_W-1:0] cnt;
    logic lvl;
  } lodhp_chan_state_type;

  lodhp_chan_state_type q;
  lodhp_chan_state_type d;

  always_comb begin
    logic [DLY_W-1:0] target;
    target = cond ? on_delay : DLY_W'(hold_time);
    d = q;
    if (!enable) begin
      d.st = 1'b0;
      d.cnt = '0;
    end else if (cond == q.st) begin
      d.cnt = '0;
    end else if (target == '0) begin
      d.st = cond;
      d.cnt = '0;
    end else if (ms_tick) begin
      if (q.cnt >= target) begin
        d.st = cond;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + DLY_W'(1);
      end
    end
    d.lvl = enable & (d.st ^ active_low);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign timed_state = q.st;

  cancel_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && cond == q.st) |=> (q.cnt == '0))
    else $error("Pending change was not cancelled.");

  zero_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && cond && !q.st && on_delay == '0) |=> q.st)
    else $error("Zero turn-on delay did not act at once.");

  no_early_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !q.st && !ms_tick && on_delay != '0) |=> !q.st)
    else $error("Output turned on before the delay elapsed.");

  zero_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && !cond && q.st && hold_time == '0) |=> !q.st)
    else $error("Zero holding time did not act at once.");

  no_early_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && q.st && !ms_tick && hold_time != '0) |=> q.st)
    else $error("Output turned off before the holding time elapsed.");

  polarity_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable |=> (q.lvl == (q.st ^ $past(active_low))))
    else $error("Output level does not follow the polarity setting.");

endmodule : lodhp_chan

/* verilog/lodhp_top.sv */
`timescale 1ns/10ps
module lodhp_top
  import lodhp_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Option card and conditions
  input wire logic card_present,
  input wire logic [NUM_SRC-1:0] cond_in,
  // Logic outputs
  output logic logic_output_third,
  output logic logic_output_fourth
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CH-1:0][SRC_W-1:0] src;
    logic [NUM_CH-1:0][DLY_W-1:0] dly;
    logic [NUM_CH-1:0] pol;
    logic [NUM_CH-1:0][HOLD_W-1:0] hold;
  } lodhp_state_type;

  lodhp_state_type q;
  lodhp_state_type d;

  logic ms_tick;
  logic [NUM_CH-1:0] lvl;
  logic [NUM_CH-1:0] timed;
  logic wr_take;
  logic rd_take;

  if (MS_CYCLES < 2) begin : g_chk
    $error("Millisecond period must be at least two cycles.");
  end

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input lodhp_state_type s, input logic [ADDR_W-1:0] a);
    logic page_ok;
    page_ok = (a[7:4] == CH_PAGE_FIRST) || (a[7:4] == CH_PAGE_LAST);
    return (a == ADDR_STATUS) || (s.sync2 && page_ok && a[1:0] == 2'h0);
  endfunction : addr_ok

  function automatic logic [DATA_W-1:0] rd_word(input lodhp_state_type s,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [NUM_CH-1:0] lv,
                                                 input logic [NUM_CH-1:0] tm);
    logic [DATA_W-1:0] r;
    logic c;
    r = '0;
    c = a[5];
    if (a == ADDR_STATUS) begin
      r[ST_CARD_BIT] = s.sync2;
      r[ST_LEVEL_BIT +: NUM_CH] = lv;
      r[ST_TIMED_BIT +: NUM_CH] = tm;
    end else if (addr_ok(s, a)) begin
      unique case (a[3:0])
        OFF_SRC: r[SRC_W-1:0] = s.src[c];
        OFF_DLY: r[DLY_W-1:0] = s.dly[c];
        OFF_POL: r[0] = s.pol[c];
        OFF_HOLD: r[HOLD_W-1:0] = s.hold[c];
        default: r = '0;
      endcase
    end
    return r;
  endfunction : rd_word

  function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] st);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{st[i]}};
    end
    return m;
  endfunction : strb_mask

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.bvalid && s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !q.rvalid;
  assign wr_take = s_axi_awready;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] wv;
    logic [DATA_W-1:0] m;
    logic ok;
    logic c;
    wv = '0;
    m = '0;
    ok = 1'b0;
    c = 1'b0;
    d = q;
    d.sync1 = card_present;
    d.sync2 = q.sync1;
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (wr_take) begin
      c = s_axi_awaddr[5];
      m = strb_mask(s_axi_wstrb);
      wv = (rd_word(q, s_axi_awaddr, lvl, timed) & ~m) | (s_axi_wdata & m);
      if (addr_ok(q, s_axi_awaddr) && s_axi_awaddr != ADDR_STATUS) begin
        unique case (s_axi_awaddr[3:0])
          OFF_SRC: begin
            if (wv[DATA_W-1:SRC_W] == '0) begin
              ok = 1'b1;
              d.src[c] = wv[SRC_W-1:0];
              if (dly_fixed(wv[SRC_W-1:0])) begin
                d.dly[c] = DLY_RST;
              end
              if (pol_locked(wv[SRC_W-1:0])) begin
                d.pol[c] = POL_RST;
              end
              if (hold_fixed(wv[SRC_W-1:0])) begin
                d.hold[c] = HOLD_RST;
              end
            end
          end
          OFF_DLY: begin
            if (!dly_fixed(q.src[c]) && wv <= DATA_W'(DLY_MAX_MS)) begin
              ok = 1'b1;
              d.dly[c] = wv[DLY_W-1:0];
            end
          end
          OFF_POL: begin
            if (wv[DATA_W-1:1] == '0 && !(pol_locked(q.src[c]) && wv[0])) begin
              ok = 1'b1;
              d.pol[c] = wv[0];
            end
          end
          OFF_HOLD: begin
            if (!hold_fixed(q.src[c]) && wv <= DATA_W'(HOLD_MAX_MS)) begin
              ok = 1'b1;
              d.hold[c] = wv[HOLD_W-1:0];
            end
          end
          default: ok = 1'b0;
        endcase
      end
      d.bvalid = 1'b1;
      d.bresp = ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rdata = rd_word(q, s_axi_araddr, lvl, timed);
      d.rresp = addr_ok(q, s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Time base and output channels
  // ----------------------------------------------------------------
  lodhp_tick #(
    .TICK_CYCLES(MS_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(ms_tick)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic sel_cond;
    assign sel_cond = (q.src[g] != SRC_NONE) && cond_in[q.src[g]];

    lodhp_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .ms_tick(ms_tick),
      .enable(q.sync2),
      .cond(sel_cond),
      .on_delay(dly_fixed(q.src[g]) ? DLY_RST : q.dly[g]),
      .hold_time(hold_fixed(q.src[g]) ? HOLD_RST : q.hold[g]),
      .active_low(pol_locked(q.src[g]) ? POL_RST : q.pol[g]),
      .level(lvl[g]),
      .timed_state(timed[g])
    );

    dly_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dly_fixed(q.src[g]) |-> (q.dly[g] == DLY_RST))
      else $error("Turn-on delay not zero for a locked assignment.");

    pol_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pol_locked(q.src[g]) |-> (q.pol[g] == POL_RST))
      else $error("Polarity not positive for a locked assignment.");

    hold_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      hold_fixed(q.src[g]) |-> (q.hold[g] == HOLD_RST))
      else $error("Holding time not zero for a locked assignment.");

    dly_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q.dly[g] <= DLY_MAX_MS)
      else $error("Turn-on delay beyond its range.");

    hold_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q.hold[g] <= HOLD_MAX_MS)
      else $error("Holding time beyond its range.");

    none_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.src[g] == SRC_NONE && !timed[g]) |=> !timed[g])
      else $error("Output with no source became active.");
  end

  assign logic_output_third = lvl[0];
  assign logic_output_fourth = lvl[1];

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  card_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.sync2 |=> (!logic_output_third && !logic_output_fourth))
    else $error("Output active without the option card.");

  default_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (q.src == '0 && q.dly == '0 && q.hold == '0 && q.pol == '0))
    else $error("Settings not at defaults after reset.");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_take |=> (s_axi_bvalid && !s_axi_awready))
    else $error("Write response did not follow the write.");

  read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take |=> (s_axi_rvalid && !s_axi_arready))
    else $error("Read data did not follow the read address.");

  bresp_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("Write response changed before it was taken.");

  rdata_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("Read data changed before it was taken.");

  absent_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_take && !q.sync2 && s_axi_awaddr != ADDR_STATUS) |=> (s_axi_bresp == RESP_SLVERR))
    else $error("Channel write accepted without the option card.");

endmodule : lodhp_top

/* verif/lodhp_tb.sv */
`timescale 1ns/10ps
module tb
  import lodhp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int MS = 4;
  logic aclk, aresetn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic card_present;
  logic [NUM_SRC-1:0] cond_in;
  logic logic_output_third, logic_output_fourth;
  int err_count = 0;
  int tests_run = 0;
  int n;

  lodhp_top #(.MS_CYCLES(MS)) lodhp_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .card_present(card_present), .cond_in(cond_in),
    .logic_output_third(logic_output_third), .logic_output_fourth(logic_output_fourth)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [ADDR_W-1:0] ch_addr(input int ch, input logic [3:0] off);
    logic [3:0] page;
    page = CH_PAGE_FIRST + 4'(ch);
    return {page, off};
  endfunction : ch_addr

  function automatic logic out_of(input int ch);
    return (ch != 0) ? logic_output_fourth : logic_output_third;
  endfunction : out_of

  // Write address and data are offered together and each is held until its own ready.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    chk(s_axi_rdata, ed);
  endtask : rd

  // Counts cycles until the output shows the level, giving up after maxc.
  task automatic wait_out(input int ch, input logic v, input int maxc, output int cnt);
    cnt = 0;
    while (out_of(ch) !== v && cnt < maxc) begin
      @(posedge aclk);
      cnt++;
    end
  endtask : wait_out

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    card_present = 1'b0;
    cond_in = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ch_addr(0, OFF_SRC), 32'h0, RESP_SLVERR);
    wr(ch_addr(1, OFF_SRC), 32'h5, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    card_present <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    for (int ch = 0; ch < 2; ch++) begin
      rd(ch_addr(ch, OFF_SRC), 32'h0, RESP_OKAY);
      rd(ch_addr(ch, OFF_DLY), 32'h0, RESP_OKAY);
      rd(ch_addr(ch, OFF_POL), 32'h0, RESP_OKAY);
      rd(ch_addr(ch, OFF_HOLD), 32'h0, RESP_OKAY);
    end
    rd(8'hfc, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    // Locked assignments: only the output contactor keeps hold and polarity free.
    for (int s = 1; s <= 4; s++) begin
      wr(ch_addr(0, OFF_SRC), 32'(s), RESP_OKAY);
      wr(ch_addr(0, OFF_DLY), 32'ha, RESP_SLVERR);
      wr(ch_addr(0, OFF_HOLD), 32'ha, (s == 2) ? RESP_OKAY : RESP_SLVERR);
      wr(ch_addr(0, OFF_POL), 32'h1, (s == 2) ? RESP_OKAY : RESP_SLVERR);
      rd(ch_addr(0, OFF_DLY), 32'h0, RESP_OKAY);
    end
    rd(ch_addr(0, OFF_POL), 32'h0, RESP_OKAY);
    rd(ch_addr(0, OFF_HOLD), 32'h0, RESP_OKAY);
    wr(ch_addr(0, OFF_SRC), 32'h5, RESP_OKAY);
    wr(ch_addr(0, OFF_DLY), 32'hea61, RESP_SLVERR);
    wr(ch_addr(0, OFF_DLY), 32'hea60, RESP_OKAY);
    rd(ch_addr(0, OFF_DLY), 32'hea60, RESP_OKAY);
    wr(ch_addr(0, OFF_HOLD), 32'h2710, RESP_SLVERR);
    wr(ch_addr(0, OFF_HOLD), 32'h270f, RESP_OKAY);
    wr(ch_addr(0, OFF_DLY), 32'h0, RESP_OKAY);
    wr(ch_addr(0, OFF_HOLD), 32'h0, RESP_OKAY);
    // Zero delay and zero hold follow the condition at once.
    cond_in[5] <= 1'b1;
    wait_out(0, 1'b1, 6, n);
    chk({31'h0, logic_output_third}, 32'h1);
    rd(ADDR_STATUS, 32'hb, RESP_OKAY);
    cond_in[5] <= 1'b0;
    wait_out(0, 1'b0, 6, n);
    chk({31'h0, logic_output_third}, 32'h0);
    // A 3 ms delay and a 2 ms hold.
    wr(ch_addr(0, OFF_DLY), 32'h3, RESP_OKAY);
    wr(ch_addr(0, OFF_HOLD), 32'h2, RESP_OKAY);
    cond_in[5] <= 1'b1;
    wait_out(0, 1'b1, 40, n);
    chk({31'h0, (n >= 3 * MS && n <= 4 * MS + 2)}, 32'h1);
    cond_in[5] <= 1'b0;
    wait_out(0, 1'b0, 40, n);
    chk({31'h0, (n >= 2 * MS && n <= 3 * MS + 2)}, 32'h1);
    // A condition that reverts early leaves the output as it was.
    wr(ch_addr(0, OFF_DLY), 32'h5, RESP_OKAY);
    cond_in[5] <= 1'b1;
    repeat (2 * MS) @(posedge aclk);
    cond_in[5] <= 1'b0;
    wait_out(0, 1'b1, 40, n);
    chk(32'(n), 32'd40);
    wr(ch_addr(0, OFF_DLY), 32'h0, RESP_OKAY);
    cond_in[5] <= 1'b1;
    wait_out(0, 1'b1, 6, n);
    cond_in[5] <= 1'b0;
    repeat (MS) @(posedge aclk);
    cond_in[5] <= 1'b1;
    wait_out(0, 1'b0, 40, n);
    chk(32'(n), 32'd40);
    // Negative polarity on the fourth output.
    wr(ch_addr(1, OFF_SRC), 32'h6, RESP_OKAY);
    wr(ch_addr(1, OFF_POL), 32'h1, RESP_OKAY);
    wait_out(1, 1'b1, 6, n);
    chk({31'h0, logic_output_fourth}, 32'h1);
    cond_in[6] <= 1'b1;
    wait_out(1, 1'b0, 6, n);
    chk({31'h0, logic_output_fourth}, 32'h0);
    cond_in[6] <= 1'b0;
    wait_out(1, 1'b1, 6, n);
    chk({31'h0, logic_output_fourth}, 32'h1);
    // Card removal drops both outputs and hides the settings.
    card_present <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({30'h0, logic_output_fourth, logic_output_third}, 32'h0);
    rd(ch_addr(1, OFF_POL), 32'h0, RESP_SLVERR);
    conclude();
  end
endmodule : tb
